/* logic/dlws_top.sv */
// line wait engine, line drivers, bank range and card status behind AXI4-Lite
// assumes pins arrive asynchronously; one wait request is serviced at a time
`timescale 1ns/100ps
import dlws_pkg::*;

// Notes on behaviour
// - either-edge wait stalls until the next transition or timeout
// - falling wait stalls until the line next goes high to low, or timeout
// - rising wait stalls until the line next goes low to high, or timeout
// - high wait stalls until the line is high, or timeout
// - low wait stalls until the line is low, or timeout
// - timeout is a signed count of clock ticks bounding the stall
// - zero timeout reports a timeout at once
// - negative timeout never times out
// - positive timeout waits at most that many ticks, then times out
// - status check is true only while the bridge output stage is ready
// - range query returns the range now in effect per bank
// - range setting picks narrow or wide bipolar range per two-channel bank
// - run-time range write replaces the configured default, queries follow it
// - each line starts with a configured direction, input by default
// - parallel-sampled inputs form eight banks of two channels each
module dlws_top #(
	parameter int NUM_LINES = 32,
	parameter logic [NUM_LINES-1:0] INIT_DIR_OUT = '0,
	parameter logic [dlws_pkg::NUM_BANKS-1:0] INIT_RANGE_WIDE = '0
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [dlws_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [dlws_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [dlws_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [dlws_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [NUM_LINES-1:0] LINE_IN,
	output logic [NUM_LINES-1:0] LINE_OUT,
	output logic [NUM_LINES-1:0] LINE_OE,
	input wire logic BRIDGE_READY_IN,
	output logic [dlws_pkg::NUM_BANKS-1:0] RANGE_WIDE,
	output logic WAIT_BUSY,
	output logic IRQ
);
	import dlws_pkg::*;

	localparam int LSEL_W = $clog2(NUM_LINES);

	// write strobe mask from byte enables
	function automatic logic [DATA_W-1:0] strb_mask(input logic [3:0] strb);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// address decode shared by read and write paths
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_WAIT_CTRL) || (a == OFS_WAIT_TIMEOUT) || (a == OFS_WAIT_STAT) ||
			(a == OFS_OUT_DATA) || (a == OFS_OUT_EN) || (a == OFS_LINE_IN) ||
			(a == OFS_RANGE) || (a == OFS_CARD_STAT) || (a == OFS_IRQ_STAT) ||
			(a == OFS_IRQ_MASK);
	endfunction

	// synchronised lines plus the bridge ready pin
	logic [NUM_LINES:0] sync_level;
	logic [NUM_LINES:0] sync_prev;

	dlws_sync #(
		.WIDTH(NUM_LINES + 1)
	) u_sync (
		.clk(CLK),
		.srst(SRST),
		.async_in({BRIDGE_READY_IN, LINE_IN}),
		.level(sync_level),
		.prev_level(sync_prev)
	);

	wire [NUM_LINES-1:0] line_now = sync_level[NUM_LINES-1:0];
	wire [NUM_LINES-1:0] line_prev = sync_prev[NUM_LINES-1:0];
	wire bridge_ready = sync_level[NUM_LINES];

	// ---------------- register bus: write path ----------------
	logic aw_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic w_held_r;
	logic [DATA_W-1:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_take = S_AXI_WVALID && S_AXI_WREADY;
	wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
	wire [DATA_W-1:0] wmask = strb_mask(w_strb_r);
	wire [DATA_W-1:0] wmasked = w_data_r & wmask;
	wire wr_ctrl = wr_fire && (aw_addr_r == OFS_WAIT_CTRL);
	wire wr_tmo = wr_fire && (aw_addr_r == OFS_WAIT_TIMEOUT);
	wire wr_odata = wr_fire && (aw_addr_r == OFS_OUT_DATA);
	wire wr_oen = wr_fire && (aw_addr_r == OFS_OUT_EN);
	wire wr_range = wr_fire && (aw_addr_r == OFS_RANGE);
	wire wr_istat = wr_fire && (aw_addr_r == OFS_IRQ_STAT);
	wire wr_imask = wr_fire && (aw_addr_r == OFS_IRQ_MASK);

	assign S_AXI_AWREADY = !aw_held_r;
	assign S_AXI_WREADY = !w_held_r;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;

	// ---------------- software registers ----------------
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] ctrl_nxt;
	logic [DATA_W-1:0] tmo_r;
	logic [NUM_LINES-1:0] odata_r;
	logic [NUM_LINES-1:0] oen_r;
	logic [NUM_BANKS-1:0] range_r;
	logic [IRQ_W-1:0] imask_r;

	// start bit is a command, not stored
	assign ctrl_nxt = (ctrl_r & ~wmask) | wmasked;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_r <= '0;
			tmo_r <= RST_TIMEOUT;
			odata_r <= '0;
			oen_r <= INIT_DIR_OUT;
			range_r <= INIT_RANGE_WIDE;
			imask_r <= RST_IRQ;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= ctrl_nxt & ~(32'h1 << CTRL_START_BIT);
			end
			if (wr_tmo) begin
				tmo_r <= (tmo_r & ~wmask) | wmasked;
			end
			if (wr_odata) begin
				odata_r <= (odata_r & ~wmask[NUM_LINES-1:0]) | wmasked[NUM_LINES-1:0];
			end
			if (wr_oen) begin
				oen_r <= (oen_r & ~wmask[NUM_LINES-1:0]) | wmasked[NUM_LINES-1:0];
			end
			if (wr_range) begin
				// one bit per two-channel bank: 0 narrow, 1 wide
				range_r <= (range_r & ~wmask[NUM_BANKS-1:0]) | wmasked[NUM_BANKS-1:0];
			end
			if (wr_imask) begin
				imask_r <= (imask_r & ~wmask[IRQ_W-1:0]) | wmasked[IRQ_W-1:0];
			end
		end
	end

	// driving lines follow output data only while enabled, else released
	assign LINE_OUT = odata_r;
	assign LINE_OE = oen_r;
	assign RANGE_WIDE = range_r;

	// ---------------- wait engine ----------------
	dlws_state_t state_r;
	dlws_state_t state_nxt;
	logic [2:0] mode_r;
	logic [LSEL_W-1:0] lsel_r;
	logic signed [DATA_W-1:0] remain_r;
	logic signed [DATA_W-1:0] remain_nxt;
	logic forever_r;
	logic met_r;
	logic timed_out_r;
	logic ev_met;
	logic ev_tmo;

	wire start_req = wr_ctrl && wmasked[CTRL_START_BIT];
	wire [2:0] req_mode = ctrl_nxt[CTRL_MODE_LSB +: 3];
	wire [LSEL_W-1:0] req_line = ctrl_nxt[CTRL_LINE_LSB +: LSEL_W];
	wire signed [DATA_W-1:0] req_tmo = tmo_r;
	wire cur = line_now[lsel_r];
	wire prv = line_prev[lsel_r];
	wire rose = cur && !prv;
	wire fell = !cur && prv;

	logic cond;
	always_comb begin
		case (mode_r)
			MODE_ANY_EDGE: cond = rose || fell;
			MODE_FALL: cond = fell;
			MODE_RISE: cond = rose;
			MODE_HIGH: cond = cur;
			MODE_LOW: cond = !cur;
			default: cond = 1'b0;
		endcase
	end

	// a condition met in the same tick as the last count wins over the timeout
	always_comb begin
		state_nxt = state_r;
		remain_nxt = remain_r;
		ev_met = 1'b0;
		ev_tmo = 1'b0;
		case (state_r)
			WS_IDLE: begin
				if (start_req) begin
					if (req_tmo == 0) begin
						ev_tmo = 1'b1;
					end else begin
						state_nxt = WS_WAIT;
						remain_nxt = req_tmo;
					end
				end
			end
			WS_WAIT: begin
				if (cond) begin
					ev_met = 1'b1;
					state_nxt = WS_IDLE;
				end else if (!forever_r) begin
					if (remain_r == 1) begin
						ev_tmo = 1'b1;
						state_nxt = WS_IDLE;
					end else begin
						remain_nxt = remain_r - 1;
					end
				end
			end
			default: state_nxt = WS_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_r <= WS_IDLE;
			remain_r <= '0;
			forever_r <= 1'b0;
			mode_r <= MODE_ANY_EDGE;
			lsel_r <= '0;
			met_r <= 1'b0;
			timed_out_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			remain_r <= remain_nxt;
			if (start_req && state_r == WS_IDLE) begin
				mode_r <= req_mode;
				lsel_r <= req_line;
				forever_r <= req_tmo < 0;
				met_r <= 1'b0;
				timed_out_r <= 1'b0;
			end
			if (ev_met) begin
				met_r <= 1'b1;
			end
			if (ev_tmo) begin
				timed_out_r <= 1'b1;
			end
		end
	end

	// busy models the stalled caller
	assign WAIT_BUSY = (state_r == WS_WAIT);

	// ---------------- interrupts ----------------
	logic [IRQ_W-1:0] istat_r;
	logic [IRQ_W-1:0] istat_set;
	logic [IRQ_W-1:0] istat_clr;

	assign istat_set[IRQ_MET_BIT] = ev_met;
	assign istat_set[IRQ_TIMEOUT_BIT] = ev_tmo;
	assign istat_clr = wr_istat ? wmasked[IRQ_W-1:0] : '0;

	// a new event wins over a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			istat_r <= RST_IRQ;
		end else begin
			istat_r <= (istat_r & ~istat_clr) | istat_set;
		end
	end

	assign IRQ = |(istat_r & imask_r);

	// ---------------- register bus: read path ----------------
	logic rvalid_r;
	logic [DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic [DATA_W-1:0] rd_mux;

	wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
	wire [DATA_W-1:0] wstat_word = {29'h0, timed_out_r, met_r, WAIT_BUSY};

	assign S_AXI_ARREADY = !rvalid_r;

	always_comb begin
		case (S_AXI_ARADDR)
			OFS_WAIT_CTRL: rd_mux = ctrl_r;
			OFS_WAIT_TIMEOUT: rd_mux = tmo_r;
			OFS_WAIT_STAT: rd_mux = wstat_word;
			OFS_OUT_DATA: rd_mux = DATA_W'(odata_r);
			OFS_OUT_EN: rd_mux = DATA_W'(oen_r);
			OFS_LINE_IN: rd_mux = DATA_W'(line_now);
			OFS_RANGE: rd_mux = DATA_W'(range_r);
			OFS_CARD_STAT: rd_mux = DATA_W'(bridge_ready);
			OFS_IRQ_STAT: rd_mux = DATA_W'(istat_r);
			OFS_IRQ_MASK: rd_mux = DATA_W'(imask_r);
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
endmodule

/* logic/dlws_pkg.sv */
// constants shared by the line wait and status block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package dlws_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_BANKS = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_WAIT_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_WAIT_TIMEOUT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WAIT_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_OUT_DATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_OUT_EN = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_LINE_IN = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CARD_STAT = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;

	// wait control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LINE_LSB = 8;
	localparam int CTRL_START_BIT = 31;

	// wait status and interrupt bit positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_MET_BIT = 1;
	localparam int STAT_TIMEOUT_BIT = 2;
	localparam int IRQ_MET_BIT = 0;
	localparam int IRQ_TIMEOUT_BIT = 1;
	localparam int IRQ_W = 2;

	// wait modes
	localparam logic [2:0] MODE_ANY_EDGE = 3'h0;
	localparam logic [2:0] MODE_FALL = 3'h1;
	localparam logic [2:0] MODE_RISE = 3'h2;
	localparam logic [2:0] MODE_HIGH = 3'h3;
	localparam logic [2:0] MODE_LOW = 3'h4;

	// values after reset
	localparam logic [DATA_W-1:0] RST_TIMEOUT = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {WS_IDLE, WS_WAIT} dlws_state_t;
endpackage

/* logic/dlws_sync.sv */
// three-stage input synchroniser with agreement filter and previous sample
// assumes asynchronous inputs and a free-running clk
`timescale 1ns/100ps
module dlws_sync #(
	parameter int WIDTH = 33
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] prev_level
);
	logic [WIDTH-1:0] ff1_r;
	logic [WIDTH-1:0] ff2_r;
	logic [WIDTH-1:0] ff3_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] prev_r;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] level_nxt;

	// a change only counts once the second and third stages agree
	assign agree = ~(ff2_r ^ ff3_r);
	assign level_nxt = (ff3_r & agree) | (level_r & ~agree);

	always_ff @(posedge clk) begin
		ff1_r <= async_in;
		ff2_r <= ff1_r;
		ff3_r <= ff2_r;
		if (srst) begin
			// load the live sample into both, so no false edge follows reset
			level_r <= ff3_r;
			prev_r <= ff3_r;
		end else begin
			level_r <= level_nxt;
			prev_r <= level_r;
		end
	end

	assign level = level_r;
	assign prev_level = prev_r;
endmodule

/* bench/dlws_pin_model.sv */
// pin-side model: resolves each line from our drive or the outside level
// assumes the outside source always drives when the block does not
`timescale 1ns/100ps
module dlws_pin_model (
	input wire logic [31:0] ext,
	input wire logic [31:0] drv,
	input wire logic [31:0] oe,
	output logic [31:0] pins
);
	assign pins = (oe & drv) | (~oe & ext);
endmodule

/* bench/dlws_assertions.sv */
// port checks for the line wait block
// assumes binding to dlws_top, single clock domain
`timescale 1ns/100ps
module dlws_assertions #(
	parameter int NUM_LINES = 32,
	parameter logic [NUM_LINES-1:0] INIT_DIR_OUT = '0,
	parameter logic [7:0] INIT_RANGE_WIDE = '0
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [NUM_LINES-1:0] LINE_OUT,
	input wire logic [NUM_LINES-1:0] LINE_OE,
	input wire logic [7:0] RANGE_WIDE,
	input wire logic WAIT_BUSY,
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("write not answered");
	a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
		&& $stable(S_AXI_BRESP)) else $error("write response dropped");
	a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
		&& $stable(S_AXI_RDATA)) else $error("read data dropped");
	a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while answer pending");
	a_reset_dir: assert property ($fell(SRST) |-> LINE_OE == INIT_DIR_OUT
		&& RANGE_WIDE == INIT_RANGE_WIDE && !WAIT_BUSY) else $error("bad state after reset");
	a_range_by_write: assert property (!$stable(RANGE_WIDE) |-> S_AXI_BVALID
		|| $past(S_AXI_AWVALID)) else $error("range changed without write");
	a_out_by_write: assert property (!$stable(LINE_OUT) || !$stable(LINE_OE)
		|-> S_AXI_BVALID || $past(S_AXI_AWVALID)) else $error("drive changed alone");
	a_busy_start: assert property ($rose(WAIT_BUSY) |-> S_AXI_BVALID
		|| $past(S_AXI_BVALID)) else $error("wait began without start");
	a_irq_clear: assert property ($fell(IRQ) |-> S_AXI_BVALID || $past(S_AXI_AWVALID))
		else $error("interrupt fell without write");
	cover property ($fell(WAIT_BUSY));
	cover property ($rose(IRQ));
	cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind dlws_top dlws_assertions #(.NUM_LINES(NUM_LINES), .INIT_DIR_OUT(INIT_DIR_OUT),
	.INIT_RANGE_WIDE(INIT_RANGE_WIDE)) dlws_assertions_inst (.CLK(CLK), .SRST(SRST),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE), .RANGE_WIDE(RANGE_WIDE),
	.WAIT_BUSY(WAIT_BUSY), .IRQ(IRQ));

/* bench/tb_dio_line_wait_and_status.sv */
// self-checking bench for dlws_top with a pin model on the lines
// assumes default parameters; line 3 is the watched line
`timescale 1ns/100ps
module tb_dio_line_wait_and_status;
	import dlws_pkg::*;
	logic clk, srst, awv, wv, bready, arv, rready, bridge, awr, wr_r, bv, arr, rv, busy, irq;
	logic [7:0] awa, ara, rng_w;
	logic [31:0] wd, rdt, rdat, ext, lin, lout, loe, od;
	logic [1:0] br, rr, resp;
	int n_mismatch = 0, cmp_count = 0, wdog = 0, busy_n = 0, msk = 0;
	int seed = 32'hf39f9e0c;
	dlws_top dlws_top_inst (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rready), .LINE_IN(lin), .LINE_OUT(lout), .LINE_OE(loe),
		.BRIDGE_READY_IN(bridge), .RANGE_WIDE(rng_w), .WAIT_BUSY(busy), .IRQ(irq));
	dlws_pin_model dlws_pin_model_inst (.ext(ext), .drv(lout), .oe(loe), .pins(lin));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		wdog++;
		if (busy) busy_n <= busy_n + 1;
		if (wdog == 20000) begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 0;
			if (wv && wr_r) wv <= 0;
		end while (!bv);
		bready <= 0;
		resp = br;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 0;
		end while (!rv);
		rready <= 0;
		rdat = rdt;
		resp = rr;
	endtask
	// model: met from the level before and after one change on line 3
	task automatic run_wait(input logic [2:0] m, input int to, input logic v0, v1);
		logic met, imm;
		int n, eb, b0;
		case (m)
			MODE_ANY_EDGE: met = v0 != v1;
			MODE_FALL: met = v0 && !v1;
			MODE_RISE: met = !v0 && v1;
			MODE_HIGH: met = v0 || v1;
			MODE_LOW: met = !v0 || !v1;
			default: met = 0;
		endcase
		imm = (m == MODE_HIGH && v0) || (m == MODE_LOW && !v0);
		if (to == 0) met = 0;
		eb = (to == 0) ? 0 : imm ? 1 : met ? -1 : to;
		ext[3] <= v0;
		repeat (8) @(posedge clk);
		wr(OFS_WAIT_TIMEOUT, to);
		b0 = busy_n;
		wr(OFS_WAIT_CTRL, 32'h8000_0300 | m);
		repeat (3) @(posedge clk);
		ext[3] <= v1;
		n = 0;
		while (busy && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (eb >= 0) chk(busy_n - b0, eb);
		rd(OFS_WAIT_STAT);
		chk(rdat, met ? 32'h2 : 32'h4);
		rd(OFS_IRQ_STAT);
		chk(rdat, met ? 32'h1 : 32'h2);
		chk({31'h0, irq}, ((met ? 1 : 2) & msk) != 0);
		wr(OFS_IRQ_STAT, 32'h3);
		chk({31'h0, irq}, 32'h0);
	endtask
	initial begin
		{awv, wv, bready, arv, rready, bridge} = 0;
		{awa, ara, wd, ext} = 0;
		srst = 1;
		repeat (16) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk(loe, 32'h0);
		chk(rng_w, 8'h0);
		rd(OFS_CARD_STAT);
		chk(rdat, 32'h0);
		bridge <= 1;
		repeat (6) @(posedge clk);
		rd(OFS_CARD_STAT);
		chk(rdat, 32'h1);
		od = $random(seed);
		wr(OFS_RANGE, od & 32'hff);
		chk(rng_w, od[7:0]);
		rd(OFS_RANGE);
		chk(rdat, od & 32'hff);
		od = $random(seed);
		ext <= $random(seed) & 32'hfff0;
		wr(OFS_OUT_DATA, od);
		wr(OFS_OUT_EN, 32'hffff_0000);
		chk(lout, od);
		chk(loe, 32'hffff_0000);
		repeat (6) @(posedge clk);
		rd(OFS_LINE_IN);
		chk(rdat, (od & 32'hffff_0000) | (ext & 32'hffff));
		wr(8'h3c, 32'h1);
		chk(resp, RESP_SLVERR);
		rd(8'h3c);
		chk(rdat, 32'h0);
		chk(resp, RESP_SLVERR);
		msk = 3;
		wr(OFS_IRQ_MASK, 32'h3);
		run_wait(MODE_ANY_EDGE, -1, 0, 1);
		run_wait(MODE_ANY_EDGE, 0, 0, 1);
		run_wait(MODE_FALL, 50, 1, 0);
		run_wait(MODE_FALL, 6, 0, 1);
		run_wait(MODE_RISE, 5, 0, 0);
		run_wait(MODE_RISE, -1, 0, 1);
		run_wait(MODE_HIGH, 20, 1, 1);
		run_wait(MODE_HIGH, 20, 0, 1);
		run_wait(MODE_LOW, 7, 1, 1);
		run_wait(MODE_LOW, -5, 1, 0);
		run_wait(3'h5, 4, 0, 1);
		msk = 0;
		wr(OFS_IRQ_MASK, 32'h0);
		run_wait(MODE_RISE, 4, 0, 0);
		final_report;
	end
endmodule
